// [hw/stepper_excitation_sequencer.sv]
/*
 Step/direction excitation sequencer of a unipolar two-phase stepper driver
 with latched protection faults and an AXI4-Lite control/status slave.
 Assumes all pins synchronous to clk; resetn is the power-on reset.
*/
`timescale 1ns/1ps
module stepper_excitation_sequencer #(
    parameter int ADDR_W = 8
) (
    // clock and power-on reset
    input wire logic clk,
    input wire logic resetn,
    // motion controller pins
    input wire logic stepIn,
    input wire logic rotation_dir,
    input wire logic exc_sel_lo,
    input wire logic exc_sel_hi,
    input wire logic edge_select,
    input wire logic enableIn,
    input wire logic system_reset_n,
    // protection detectors
    input wire logic openDetect,
    input wire logic overCurrentDetect,
    input wire logic overHeatDetect,
    // phase drive and current levels
    output logic phaseA,
    output logic phase_a_bar,
    output logic phaseB,
    output logic phase_b_bar,
    output logic [6:0] currentA,
    output logic [6:0] currentB,
    output logic excitation_monitor_out,
    // open-drain fault line
    input wire logic fault_flag_n_in,
    output logic fault_flag_n_out,
    output logic fault_flag_n_oe,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    if (ADDR_W < stepper_pkg::REG_ADDR_W) begin : g_addr_check
        $error("ADDR_W too narrow for the register map");
    end

    stepper_pkg::state_type st_reg;
    stepper_pkg::state_type st_next;
    stepper_pkg::exc_mode_type mode;
    logic [stepper_pkg::POS_W-1:0] stepSize;
    logic [stepper_pkg::POS_W-1:0] rawPos;
    logic [4:0] aIdx;
    logic [4:0] bIdx;
    logic aNeg;
    logic bNeg;
    logic flatCurrent;
    logic driveOn;
    logic outputsOn;
    logic stepRise;
    logic stepFall;
    logic stepHit;
    logic [31:0] statusWord;

    ////////////////////////////////////////////////////////////////////////
    // decoding helpers
    function automatic stepper_pkg::exc_mode_type decodeMode(
        input logic edgeSel, input logic hi, input logic lo);
        case ({edgeSel, hi, lo})
            3'h4: decodeMode = stepper_pkg::EXC_2PH;
            3'h5: decodeMode = stepper_pkg::EXC_12;
            3'h6: decodeMode = stepper_pkg::EXC_W12;
            3'h7: decodeMode = stepper_pkg::EXC_2W12;
            3'h0: decodeMode = stepper_pkg::EXC_12;
            3'h1: decodeMode = stepper_pkg::EXC_W12;
            3'h2: decodeMode = stepper_pkg::EXC_2W12;
            default: decodeMode = stepper_pkg::EXC_4W12;
        endcase
    endfunction

    function automatic logic [6:0] currentLevel(input logic [4:0] idx, input logic flat);
        if (idx == 5'h00) begin
            currentLevel = stepper_pkg::CURRENT_OFF;
        end else if (flat) begin
            currentLevel = stepper_pkg::CURRENT_FULL;
        end else begin
            currentLevel = stepper_pkg::CURRENT_TABLE[idx];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next = st_reg;
        statusWord = 32'h0;
        mode = decodeMode(edge_select, exc_sel_hi, exc_sel_lo);
        case (mode)
            stepper_pkg::EXC_2PH: stepSize = stepper_pkg::SIZE_2PH;
            stepper_pkg::EXC_12: stepSize = stepper_pkg::SIZE_12;
            stepper_pkg::EXC_W12: stepSize = stepper_pkg::SIZE_W12;
            stepper_pkg::EXC_2W12: stepSize = stepper_pkg::SIZE_2W12;
            default: stepSize = stepper_pkg::SIZE_4W12;
        endcase
        stepRise = stepIn && !st_reg.stepPrev;
        stepFall = !stepIn && st_reg.stepPrev;
        st_next.stepPrev = stepIn;
        driveOn = enableIn && st_reg.ctrlEnable;
        stepHit = driveOn && (stepRise || (!edge_select && stepFall));
        // count up clockwise, down counterclockwise, snap to mode grid
        rawPos = rotation_dir ? st_reg.pos - stepSize : st_reg.pos + stepSize;
        if (!system_reset_n) begin
            st_next.pos = stepper_pkg::POS_RESET;
            st_next.monitor = 1'b0;
        end else if (stepHit) begin
            st_next.pos = rawPos & ~(stepSize - 6'h01);
            if (mode == stepper_pkg::EXC_2PH) begin
                st_next.pos[3:0] = stepper_pkg::TWO_PHASE_OFFSET;
            end
            if (st_next.pos[2:0] == 3'h0) begin
                st_next.monitor = !st_reg.monitor;
            end
        end
        // latched faults, a detection wins over the clearing reset pin
        st_next.fault = (st_reg.fault & {3{system_reset_n}})
            | {overHeatDetect, overCurrentDetect, openDetect};
        // phase and current from the new position
        aIdx = st_next.pos[4] ? {1'b0, st_next.pos[3:0]}
            : stepper_pkg::QUARTER_STEPS - {1'b0, st_next.pos[3:0]};
        bIdx = st_next.pos[4] ? stepper_pkg::QUARTER_STEPS - {1'b0, st_next.pos[3:0]}
            : {1'b0, st_next.pos[3:0]};
        aNeg = st_next.pos[5] ^ st_next.pos[4];
        bNeg = st_next.pos[5];
        flatCurrent = (mode == stepper_pkg::EXC_2PH)
            || (mode == stepper_pkg::EXC_12 && edge_select);
        outputsOn = driveOn && (st_next.fault == 3'h0);
        st_next.phase = 4'h0;
        st_next.curA = stepper_pkg::CURRENT_OFF;
        st_next.curB = stepper_pkg::CURRENT_OFF;
        if (outputsOn) begin
            st_next.phase[stepper_pkg::PH_A] = (aIdx != 5'h00) && !aNeg;
            st_next.phase[stepper_pkg::PH_A_BAR] = (aIdx != 5'h00) && aNeg;
            st_next.phase[stepper_pkg::PH_B] = (bIdx != 5'h00) && !bNeg;
            st_next.phase[stepper_pkg::PH_B_BAR] = (bIdx != 5'h00) && bNeg;
            st_next.curA = currentLevel(aIdx, flatCurrent);
            st_next.curB = currentLevel(bIdx, flatCurrent);
        end

        // axi write: address and data in either order, then one response
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.awGot = 1'b1;
            st_next.awAddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.wGot = 1'b1;
            st_next.wData = s_axi_wdata;
            st_next.wStrb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_next.awGot && st_next.wGot && !st_reg.bvalid) begin
            st_next.bvalid = 1'b1;
            st_next.bresp = stepper_pkg::RESP_OKAY;
            st_next.awGot = 1'b0;
            st_next.wGot = 1'b0;
            if (st_next.awAddr == stepper_pkg::CTRL_ADDR) begin
                if (st_next.wStrb[0]) begin
                    st_next.ctrlEnable = st_next.wData[stepper_pkg::CTRL_ENABLE_BIT];
                end
            end else if (st_next.awAddr != stepper_pkg::STATUS_ADDR) begin
                st_next.bresp = stepper_pkg::RESP_DECERR;
            end
        end
        st_next.awready = !st_next.awGot && !st_next.bvalid;
        st_next.wready = !st_next.wGot && !st_next.bvalid;

        // axi read
        statusWord[stepper_pkg::STATUS_POS_LSB +: stepper_pkg::POS_W] = st_reg.pos;
        statusWord[stepper_pkg::STATUS_FAULT_LSB +: 3] = st_reg.fault;
        statusWord[stepper_pkg::STATUS_MODE_LSB +: 3] = mode;
        statusWord[stepper_pkg::STATUS_MONITOR_BIT] = st_reg.monitor;
        statusWord[stepper_pkg::STATUS_FLAG_PIN_BIT] = fault_flag_n_in;
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = stepper_pkg::RESP_OKAY;
            case (s_axi_araddr[7:0])
                stepper_pkg::CTRL_ADDR: st_next.rdata = {31'h0, st_reg.ctrlEnable};
                stepper_pkg::STATUS_ADDR: st_next.rdata = statusWord;
                default: begin
                    st_next.rdata = 32'h0;
                    st_next.rresp = stepper_pkg::RESP_DECERR;
                end
            endcase
        end
        st_next.arready = !st_next.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg <= '0;
            // track the pin level so a high step input gives no false edge after reset
            st_reg.stepPrev <= stepIn;
            st_reg.ctrlEnable <= stepper_pkg::CTRL_ENABLE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign phaseA = st_reg.phase[stepper_pkg::PH_A];
    assign phase_a_bar = st_reg.phase[stepper_pkg::PH_A_BAR];
    assign phaseB = st_reg.phase[stepper_pkg::PH_B];
    assign phase_b_bar = st_reg.phase[stepper_pkg::PH_B_BAR];
    assign currentA = st_reg.curA;
    assign currentB = st_reg.curB;
    assign excitation_monitor_out = st_reg.monitor;
    assign fault_flag_n_out = 1'b0;
    assign fault_flag_n_oe = |st_reg.fault;
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic en;
    assign en = enableIn && st_reg.ctrlEnable && system_reset_n;

    two_phase_grid_a: assert property (en && stepRise && edge_select && !exc_sel_hi
        && !exc_sel_lo |=> st_reg.pos[3:0] == stepper_pkg::TWO_PHASE_OFFSET)
        else $error("2-phase step off grid");
    flat_current_a: assert property (edge_select && !exc_sel_hi && exc_sel_lo
        |=> st_reg.curA == stepper_pkg::CURRENT_OFF || st_reg.curA == stepper_pkg::CURRENT_FULL)
        else $error("1-2 rising mode not at full current");
    fall_ignored_a: assert property (en && stepFall && edge_select
        |=> $stable(st_reg.pos))
        else $error("falling edge moved single-edge sequence");
    both_edge_a: assert property (en && stepFall && !edge_select && exc_sel_hi
        && exc_sel_lo && !rotation_dir |=> st_reg.pos == $past(st_reg.pos) + 6'h01)
        else $error("falling edge did not step");
    ccw_count_a: assert property (en && stepRise && !edge_select && exc_sel_hi
        && exc_sel_lo && rotation_dir |=> st_reg.pos == $past(st_reg.pos) - 6'h01)
        else $error("counterclockwise step wrong");
    disable_hold_a: assert property (!enableIn && system_reset_n
        |=> st_reg.phase == 4'h0 && $stable(st_reg.pos))
        else $error("disabled driver moved or drove");
    reset_init_a: assert property (!system_reset_n |=> st_reg.pos == stepper_pkg::POS_RESET)
        else $error("reset pin did not initialise position");
    fault_flag_a: assert property (overHeatDetect ##1 system_reset_n
        |-> fault_flag_n_oe ##1 fault_flag_n_oe)
        else $error("fault line not pulled low");
    fault_latch_a: assert property (st_reg.fault[stepper_pkg::FAULT_OPEN] && system_reset_n
        |=> st_reg.fault[stepper_pkg::FAULT_OPEN] && st_reg.phase == 4'h0)
        else $error("fault lost or drive left on");
    pos_still_a: assert property (!stepRise && !stepFall && system_reset_n
        |=> $stable(st_reg.pos))
        else $error("position moved without step edge");
    monitor_point_a: assert property ($changed(st_reg.monitor) && $past(system_reset_n)
        |-> st_reg.pos[2:0] == 3'h0)
        else $error("monitor toggled off its point");

    fault_seen_c: cover property (overCurrentDetect ##1 fault_flag_n_oe ##[1:1000]
        !system_reset_n);
    micro_run_c: cover property (en && !edge_select && exc_sel_hi && exc_sel_lo && stepRise
        ##[1:1000] stepFall);
    ccw_wrap_c: cover property (en && rotation_dir && stepHit && st_reg.pos == 6'h00);
    reg_write_c: cover property (s_axi_bvalid && s_axi_bready);

endmodule // stepper_excitation_sequencer

// [hw/stepper_pkg.sv]
/*
 Holds the shared constants and types of the stepper excitation sequencer:
 register map, field positions, excitation modes, step sizes, current table
 and the sequencer state record.
 Assumes a 32-bit AXI4-Lite register bus and one system clock.
*/
package stepper_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam int REG_ADDR_W = 8;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'h1;
    localparam int STATUS_POS_LSB = 0;
    localparam int STATUS_FAULT_LSB = 8;
    localparam int STATUS_MODE_LSB = 12;
    localparam int STATUS_MONITOR_BIT = 16;
    localparam int STATUS_FLAG_PIN_BIT = 17;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // sequencer constants
    localparam int POS_W = 6;
    localparam logic [POS_W-1:0] POS_RESET = 6'h00;
    localparam logic [3:0] TWO_PHASE_OFFSET = 4'h8;
    localparam logic [4:0] QUARTER_STEPS = 5'h10;
    localparam int FAULT_OPEN = 0;
    localparam int FAULT_OVERCURRENT = 1;
    localparam int FAULT_OVERHEAT = 2;
    localparam int PH_A = 0;
    localparam int PH_A_BAR = 1;
    localparam int PH_B = 2;
    localparam int PH_B_BAR = 3;
    localparam logic [6:0] CURRENT_FULL = 7'h64;
    localparam logic [6:0] CURRENT_OFF = 7'h00;
    // percent of set current for theta = idx/16 of a quarter
    localparam logic [16:0][6:0] CURRENT_TABLE = {
        7'h64, 7'h64, 7'h61, 7'h5f, 7'h5d, 7'h57, 7'h53, 7'h4d, 7'h47,
        7'h40, 7'h37, 7'h2f, 7'h28, 7'h1e, 7'h14, 7'h0b, 7'h00};

    typedef enum logic [2:0] {
        EXC_2PH, EXC_12, EXC_W12, EXC_2W12, EXC_4W12
    } exc_mode_type;

    localparam logic [POS_W-1:0] SIZE_2PH = 6'h10;
    localparam logic [POS_W-1:0] SIZE_12 = 6'h08;
    localparam logic [POS_W-1:0] SIZE_W12 = 6'h04;
    localparam logic [POS_W-1:0] SIZE_2W12 = 6'h02;
    localparam logic [POS_W-1:0] SIZE_4W12 = 6'h01;

    typedef struct packed {
        logic [POS_W-1:0] pos;
        logic stepPrev;
        logic monitor;
        logic [2:0] fault;
        logic [3:0] phase;
        logic [6:0] curA;
        logic [6:0] curB;
        logic ctrlEnable;
        logic awGot;
        logic wGot;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_type;

endpackage

// [verification/step_controller_model.sv]
/*
 Motion controller model: drives step, direction and mode pins.
 Assumes the bench calls move() after reset, from one process only.
*/
`timescale 1ns/1ps
module step_controller_model #(
    parameter int SETUP = 175,
    parameter int GAP = 625
) (
    // clock
    input wire logic clk,
    // controller pins
    output logic stepIn = 1'b0,
    output logic rotation_dir = 1'b0,
    output logic exc_sel_lo = 1'b0,
    output logic exc_sel_hi = 1'b0,
    output logic edge_select = 1'b1
);
    ////////////////////////////////////////////////////////////////////////
    // pins settle before the edge, then hold for a full pulse half
    task automatic move(input logic dir, input logic [2:0] mode, input logic tog);
        @(posedge clk);
        rotation_dir <= dir;
        {edge_select, exc_sel_hi, exc_sel_lo} <= mode;
        repeat (SETUP) @(posedge clk);
        stepIn <= stepIn ^ tog;
        repeat (GAP) @(posedge clk);
    endtask
endmodule // step_controller_model

// [verification/test_stepper_excitation_sequencer.sv]
/*
 Self-checking bench of the stepper excitation sequencer.
 Assumes the package and the controller model are compiled first.
*/
`timescale 1ns/1ps
module test_stepper_excitation_sequencer;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic enableIn = 1'b0;
    logic system_reset_n = 1'b0;
    logic [2:0] det = 3'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic stepIn, rotation_dir, exc_sel_lo, exc_sel_hi, edge_select;
    logic phaseA, phase_a_bar, phaseB, phase_b_bar, excitation_monitor_out;
    logic fault_flag_n_out, fault_flag_n_oe;
    logic [6:0] currentA, currentB;
    wire logic fault_flag_n_in = fault_flag_n_oe ? fault_flag_n_out : 1'b1;
    int err_total = 0;
    int compares = 0;
    logic [5:0] pos = 6'h00;
    logic expMon = 1'b0;
    logic live = 1'b1;
    logic [2:0] m;
    logic [6:0] tbl [17] = '{7'h00, 7'h0b, 7'h14, 7'h1e, 7'h28, 7'h2f, 7'h37, 7'h40, 7'h47,
        7'h4d, 7'h53, 7'h57, 7'h5d, 7'h5f, 7'h61, 7'h64, 7'h64};

    always #20 clk = ~clk;

    step_controller_model ctl (
        .clk, .stepIn, .rotation_dir, .exc_sel_lo, .exc_sel_hi, .edge_select
    );
    stepper_excitation_sequencer dut (
        .clk, .resetn, .stepIn, .rotation_dir, .exc_sel_lo, .exc_sel_hi, .edge_select,
        .enableIn, .system_reset_n, .openDetect(det[0]), .overCurrentDetect(det[1]),
        .overHeatDetect(det[2]), .phaseA, .phase_a_bar, .phaseB, .phase_b_bar, .currentA,
        .currentB, .excitation_monitor_out, .fault_flag_n_in, .fault_flag_n_out,
        .fault_flag_n_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    ////////////////////////////////////////////////////////////////////////
    // expectations
    function automatic logic [2:0] code(input logic [2:0] md);
        return {1'b0, md[1:0]} + {2'b00, ~md[2]};
    endfunction
    function automatic logic [5:0] nextPos(input logic [5:0] p, input logic d,
        input logic [2:0] md);
        logic [5:0] sz;
        sz = 6'h10 >> code(md);
        return ((d ? p - sz : p + sz) & ~(sz - 6'h01))
            | ((code(md) == 3'h0) ? {2'b00, stepper_pkg::TWO_PHASE_OFFSET} : 6'h00);
    endfunction
    function automatic logic [6:0] expCur(input logic [5:0] p, input logic full);
        logic [4:0] idx;
        idx = p[4] ? {1'b0, p[3:0]} : 5'h10 - {1'b0, p[3:0]};
        return (full && idx != 5'h00) ? 7'h64 : tbl[idx];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chkPhase(input logic [5:0] p, input logic full, input logic a,
        input logic ab);
        logic n;
        n = p[5] ^ p[4];
        if (expCur(p, full) != 7'h00) check(32'({a, ab}), 32'({~n, n}));
        else check(32'({a, ab}), 32'h0);
    endtask
    task automatic chkAll(input logic [2:0] md);
        logic full;
        full = md[2] && !md[1];
        check(32'(excitation_monitor_out), 32'(expMon));
        if (live) begin
            check(32'(currentA), 32'(expCur(pos, full)));
            check(32'(currentB), 32'(expCur(pos - 6'h10, full)));
            chkPhase(pos, full, phaseA, phase_a_bar);
            chkPhase(pos - 6'h10, full, phaseB, phase_b_bar);
        end else
            check({phaseA, phase_a_bar, phaseB, phase_b_bar, currentA, currentB}, 32'h0);
    endtask
    task automatic stepOnce(input logic d, input logic [2:0] md, input logic tog);
        logic rise;
        rise = ~stepIn;
        ctl.move(d, md, tog);
        if (tog && live && (rise || !md[2])) begin
            pos = nextPos(pos, d, md);
            if (pos[2:0] == 3'h0) expMon = ~expMon;
        end
        chkAll(md);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // register bus master
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(67468));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        system_reset_n <= 1'b1;
        enableIn <= 1'b1;
        repeat (250) @(posedge clk);
        chkAll(3'b100);
        axiRead(stepper_pkg::CTRL_ADDR);
        check(rd, 32'h1);
        axiRead(8'h08);
        check(rd, 32'h0);
        check(32'(rsp), 32'(stepper_pkg::RESP_DECERR));
        axiWrite(stepper_pkg::STATUS_ADDR, 32'hffffffff);
        check(32'(rsp), 32'(stepper_pkg::RESP_OKAY));
        for (int i = 0; i < 8; i++) begin
            ctl.move(1'b0, 3'(i), 1'b0);
            axiRead(stepper_pkg::STATUS_ADDR);
            check(32'(rd[14:12]), 32'(code(3'(i))));
        end
        stepOnce(1'b0, 3'b011, 1'b1);
        stepOnce(1'b0, 3'b011, 1'b1);
        stepOnce(1'b0, 3'b000, 1'b1);
        stepOnce(1'b0, 3'b000, 1'b1);
        stepOnce(1'b0, 3'b101, 1'b1);
        stepOnce(1'b0, 3'b101, 1'b1);
        stepOnce(1'b1, 3'b111, 1'b1);
        stepOnce(1'b1, 3'b111, 1'b1);
        stepOnce(1'b0, 3'b100, 1'b1);
        stepOnce(1'b0, 3'b100, 1'b1);
        enableIn <= 1'b0;
        live = 1'b0;
        stepOnce(1'b0, 3'b011, 1'b1);
        enableIn <= 1'b1;
        live = 1'b1;
        stepOnce(1'b0, 3'b011, 1'b0);
        axiWrite(stepper_pkg::CTRL_ADDR, 32'h0);
        live = 1'b0;
        stepOnce(1'b1, 3'b011, 1'b1);
        axiWrite(stepper_pkg::CTRL_ADDR, 32'h1);
        live = 1'b1;
        repeat (40) begin
            m = 3'($urandom);
            stepOnce(1'($urandom), m, 1'($urandom | 3));
        end
        axiRead(stepper_pkg::STATUS_ADDR);
        check(32'(rd[5:0]), 32'(pos));
        for (int i = 0; i < 3; i++) begin
            det <= 3'(1 << i);
            @(posedge clk);
            det <= 3'h0;
            live = 1'b0;
            stepOnce(rotation_dir, m, 1'b0);
            check(32'(fault_flag_n_oe), 32'h1);
            axiRead(stepper_pkg::STATUS_ADDR);
            check(32'(rd[10:8]), 32'(1 << i));
            check(32'(rd[17]), 32'h0);
            system_reset_n <= 1'b0;
            repeat (2) @(posedge clk);
            system_reset_n <= 1'b1;
            {pos, expMon, live} = {6'h00, 1'b0, 1'b1};
            stepOnce(rotation_dir, m, 1'b0);
            check(32'(fault_flag_n_oe), 32'h0);
        end
        stepOnce(1'b0, 3'b011, 1'b1);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        {pos, expMon} = {6'h00, 1'b0};
        stepOnce(1'b0, 3'b011, 1'b0);
        summarize();
    end

    initial begin
        repeat (95000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule // test_stepper_excitation_sequencer
